// ===== core/fpr_chan_if.sv
/*
 fpr_chan_if: per-channel wiring between the register top, the target
 calculator and the slew stepper.
 assumes: one instance per channel, all on aclk.
*/
`timescale 1ns/1ps
interface fpr_chan_if;
   logic reading_valid;
   logic [7:0] temp;
   logic [7:0] low_limit;
   logic [7:0] span;
   logic [7:0] floor_duty;
   logic [7:0] target;
   logic slew_en;
   logic [2:0] step_sel;
   logic ms_tick;
   logic [7:0] duty;

   modport top (output reading_valid, temp, low_limit, span, floor_duty,
                output slew_en, step_sel, ms_tick, input duty);
   modport calc (input reading_valid, temp, low_limit, span, floor_duty,
                 output target);
   modport slew (input target, slew_en, step_sel, ms_tick, output duty);
endinterface

// ===== core/fpr_pkg.sv
/*
 fpr_pkg: register map, field layout, reset values and timing for the
 fan duty slew limiter.
 assumes: 100 MHz aclk, 32-bit AXI4-Lite, byte address = 4 * index.
*/
package fpr_pkg;
   // bus geometry
   localparam int AXI_AW = 12;
   localparam int AXI_DW = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   ////////////////////////////////////////////////////////////////////
   // register indices (byte address is four times these)
   localparam logic [7:0] IDX_SLEW1 = 8'h62;
   localparam logic [7:0] IDX_SLEW23 = 8'h63;
   localparam logic [7:0] IDX_FLOOR1 = 8'h64;
   localparam logic [7:0] IDX_FLOOR2 = 8'h65;
   localparam logic [7:0] IDX_FLOOR3 = 8'h66;
   localparam logic [7:0] IDX_LOCK = 8'h70;
   localparam logic [7:0] IDX_DUTY = 8'h71;
   ////////////////////////////////////////////////////////////////////
   // reset values and write masks
   localparam logic [7:0] RST_SLEW1 = 8'hE0;
   localparam logic [7:0] RST_SLEW23 = 8'h00;
   localparam logic [7:0] RST_FLOOR = 8'h80;
   localparam logic [7:0] SLEW1_WMASK = 8'h0F;
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [7:0] DUTY_ZERO = 8'h00;
   // field positions
   localparam int LOCK_BIT = 0;
   localparam int EN_LO = 3;
   localparam int EN_HI = 7;
   localparam int SEL_LO = 0;
   localparam int SEL_HI = 4;
   localparam int SEL_W = 3;
   localparam int CH_N = 3;
   ////////////////////////////////////////////////////////////////////
   // timing: step intervals in ms, ms in cycles
   localparam int CLK_HZ = 100_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam logic [7:0] STEP_MS [8] = '{8'hCE, 8'h68, 8'h45, 8'h29,
                                          8'h1A, 8'h12, 8'h0A, 8'h05};

   // step interval for a selector value, in ms ticks
   function automatic logic [7:0] step_ms(input logic [SEL_W-1:0] sel);
      step_ms = STEP_MS[sel];
   endfunction
endpackage

// ===== core/fpr_slew_step.sv
/*
 fpr_slew_step: output duty of one channel, direct or stepped one count
 per selected interval toward the target.
 assumes: ms_tick is a one-cycle pulse every millisecond.
*/
`timescale 1ns/1ps
module fpr_slew_step
   import fpr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   fpr_chan_if.slew ch
);
   typedef struct packed {
      logic [7:0] duty;
      logic [7:0] ms_cnt;
   } fpr_slew_st_t;

   fpr_slew_st_t st_r;
   fpr_slew_st_t st_nxt;

   // direct follow, or one count per interval in either direction
   always_comb begin
      st_nxt = st_r;
      if (!ch.slew_en) begin
         st_nxt.duty = ch.target; // R4
         st_nxt.ms_cnt = 8'h00;
      end else if (ch.ms_tick) begin
         if (st_r.ms_cnt + 8'h01 >= step_ms(ch.step_sel)) begin // R6 R7
            st_nxt.ms_cnt = 8'h00;
            if (st_r.duty < ch.target) begin
               st_nxt.duty = st_r.duty + 8'h01; // R5 R12
            end else if (st_r.duty > ch.target) begin
               st_nxt.duty = st_r.duty - 8'h01; // R5 R12
            end
         end else begin
            st_nxt.ms_cnt = st_r.ms_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ch.duty = st_r.duty;
endmodule // fpr_slew_step

// ===== core/fpr_target_calc.sv
/*
 fpr_target_calc: target duty for one channel from each temperature
 reading, floor at or below the low limit, linear up to full duty.
 assumes: signed 8-bit temperatures, span in whole degrees.
*/
`timescale 1ns/1ps
module fpr_target_calc
   import fpr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   fpr_chan_if.calc ch
);
   typedef struct packed {
      logic [7:0] target;
   } fpr_calc_st_t;

   fpr_calc_st_t st_r;
   fpr_calc_st_t st_nxt;
   logic signed [8:0] diff;
   logic [15:0] prod;
   logic [15:0] quot;

   // position inside the span; span zero means full one degree above the limit
   assign diff = $signed({ch.temp[7], ch.temp}) - $signed({ch.low_limit[7], ch.low_limit});
   assign prod = (DUTY_FULL - ch.floor_duty) * diff[7:0];
   assign quot = (ch.span == DUTY_ZERO) ? 16'h0000 : prod / {8'h00, ch.span};

   // new target on every reading
   always_comb begin
      st_nxt = st_r;
      if (ch.reading_valid) begin // R3
         if (diff <= 0) begin
            st_nxt.target = ch.floor_duty; // R2 R9
         end else if (diff >= $signed({1'b0, ch.span})) begin
            st_nxt.target = DUTY_FULL; // R11
         end else begin
            st_nxt.target = ch.floor_duty + quot[7:0]; // R11
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ch.target = st_r.target;
endmodule // fpr_target_calc

// ===== core/fpr_top.sv
/*
 fpr_top: three-channel fan duty slew limiter with duty floors, lockable
 byte registers behind an AXI4-Lite slave.
 assumes: temperatures and limits arrive synchronous to aclk; the
 auto-fan zone logic outside supplies readings, limits and spans.
*/
// Operation
// R1 - lock freezes slew and floor registers
// R2 - below low limit duty equals floor
// R3 - new target computed every reading
// R4 - slew off: target applied at once
// R5 - slew on: ramp up and down gradually
// R6 - interval length chosen by selector bits
// R7 - one count per 206..5 ms interval
// R8 - enable and selector bit positions per channel
// R9 - floor register value gives duty at limit
// R10 - channel slew enables act independently
// R11 - linear from floor to full over span
// R12 - step exactly one count, stop at target
`timescale 1ns/1ps
module fpr_top
   import fpr_pkg::*;
#(
   parameter int unsigned MS_CYCLES = CYC_PER_MS
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [CH_N-1:0] reading_valid,
   input wire logic [CH_N-1:0][7:0] temp_reading,
   input wire logic [CH_N-1:0][7:0] low_limit,
   input wire logic [CH_N-1:0][7:0] zone_span,
   output logic [CH_N-1:0][7:0] duty_out,
   output logic lock_status
);
   ////////////////////////////////////////////////////////////////////
   // state

   // every register of this module lives in one bundle so the reset
   // values and the next-state logic cannot drift apart
   typedef struct packed {
      logic [7:0] slew1;
      logic [7:0] slew23;
      logic [CH_N-1:0][7:0] floor_duty;
      logic lock;
      logic [31:0] ms_cnt;
      logic ms_tick;
      logic aw_held;
      logic [AXI_AW-1:0] awaddr;
      logic w_held;
      logic [AXI_DW-1:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [AXI_DW-1:0] rdata;
      logic [1:0] rresp;
   } fpr_top_st_t;

   fpr_top_st_t st_r;
   fpr_top_st_t st_nxt;
   logic [CH_N-1:0] slew_en;
   logic [CH_N-1:0][SEL_W-1:0] step_sel;
   logic [CH_N-1:0][7:0] duty_w;

   ////////////////////////////////////////////////////////////////////
   // address decode, shared by the read and write paths

   // word index of a byte address; upper bits must be zero
   // the two byte-lane bits are dropped, so unaligned addresses alias
   function automatic logic [7:0] word_idx(input logic [AXI_AW-1:0] addr);
      word_idx = addr[9:2];
   endfunction

   // mapped only inside the low 1 KiB and at a listed index
   function automatic logic is_mapped(input logic [AXI_AW-1:0] addr);
      logic [7:0] idx;
      idx = word_idx(addr);
      is_mapped = 1'b0;
      if (addr[AXI_AW-1:10] == '0) begin
         case (idx)
            IDX_SLEW1,
            IDX_SLEW23,
            IDX_FLOOR1,
            IDX_FLOOR2,
            IDX_FLOOR3,
            IDX_LOCK,
            IDX_DUTY: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // field extraction for the three channels

   // channel 1 sits in the low nibble of its own register
   // channel 2 takes the high nibble and channel 3 the low nibble of the shared one
   always_comb begin
      slew_en[0] = st_r.slew1[EN_LO]; // R8
      step_sel[0] = st_r.slew1[SEL_LO +: SEL_W]; // R8
      slew_en[1] = st_r.slew23[EN_HI]; // R8
      step_sel[1] = st_r.slew23[SEL_HI +: SEL_W]; // R8
      slew_en[2] = st_r.slew23[EN_LO]; // R8
      step_sel[2] = st_r.slew23[SEL_LO +: SEL_W]; // R8
   end

   ////////////////////////////////////////////////////////////////////
   // next state: ms prescaler, write path, read path

   always_comb begin
      st_nxt = st_r;

      // shared millisecond pulse; one divider serves all channels
      // one counter instead of three; the price is that a freshly
      // enabled channel starts its first interval mid-millisecond
      st_nxt.ms_tick = 1'b0;
      if (st_r.ms_cnt >= MS_CYCLES - 1) begin
         st_nxt.ms_cnt = '0;
         st_nxt.ms_tick = 1'b1;
      end else begin
         st_nxt.ms_cnt = st_r.ms_cnt + 32'h1;
      end

      // perform a held write once address and data are both in
      // a pending response blocks the next write, so no bresp is lost
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = is_mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
         // locked writes are dropped but still answered okay
         // software must read back to learn that a write was ignored
         if (st_r.wstrb[0] && !st_r.lock) begin // R1
            case (word_idx(st_r.awaddr))
               IDX_SLEW1: begin
                  // reserved upper bits keep their reset pattern
                  st_nxt.slew1 = (st_r.slew1 & ~SLEW1_WMASK) |
                                 (st_r.wdata[7:0] & SLEW1_WMASK);
               end
               IDX_SLEW23: begin
                  st_nxt.slew23 = st_r.wdata[7:0];
               end
               IDX_FLOOR1: begin
                  st_nxt.floor_duty[0] = st_r.wdata[7:0];
               end
               IDX_FLOOR2: begin
                  st_nxt.floor_duty[1] = st_r.wdata[7:0];
               end
               IDX_FLOOR3: begin
                  st_nxt.floor_duty[2] = st_r.wdata[7:0];
               end
               IDX_LOCK: begin
                  // set only; a reset is the one way out
                  // a zero written while unlocked simply leaves it clear
                  st_nxt.lock = st_r.wdata[LOCK_BIT]; // R1
               end
               default: begin
                  st_nxt.lock = st_r.lock;
               end
            endcase
         end
      end

      // write response retires on bready
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // capture address and data independently, either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end

      // read data registered in the cycle after the address
      // unmapped or reserved words read as zero with an error response
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         st_nxt.rdata = '0;
         if (is_mapped(s_axi_araddr)) begin
            case (word_idx(s_axi_araddr))
               IDX_SLEW1: begin
                  st_nxt.rdata[7:0] = st_r.slew1;
               end
               IDX_SLEW23: begin
                  st_nxt.rdata[7:0] = st_r.slew23;
               end
               IDX_FLOOR1: begin
                  st_nxt.rdata[7:0] = st_r.floor_duty[0];
               end
               IDX_FLOOR2: begin
                  st_nxt.rdata[7:0] = st_r.floor_duty[1];
               end
               IDX_FLOOR3: begin
                  st_nxt.rdata[7:0] = st_r.floor_duty[2];
               end
               IDX_LOCK: begin
                  st_nxt.rdata[LOCK_BIT] = st_r.lock;
               end
               IDX_DUTY: begin
                  // live output duties, channel 1 in the low byte
                  // read-only status; a write to this word is answered but changes nothing
                  st_nxt.rdata[23:0] = duty_w;
               end
               default: begin
                  st_nxt.rdata = '0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   // synchronous reset; fields with non-zero defaults are set after the
   // blanket clear, which the later assignment overrides
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.slew1 <= RST_SLEW1;
         st_r.slew23 <= RST_SLEW23;
         st_r.floor_duty <= {CH_N{RST_FLOOR}};
         st_r.bresp <= RESP_OKAY;
         st_r.rresp <= RESP_OKAY;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // bus handshakes: one read in flight at most; a second write can be held while a write response waits

   // readies come straight from held flags: no path from valid to
   // ready, so a master cannot build a loop through this slave
   // protection bits are accepted and ignored; every access is alike
   assign s_axi_awready = !st_r.aw_held;
   assign s_axi_wready = !st_r.w_held;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign lock_status = st_r.lock;
   assign duty_out = duty_w;

   ////////////////////////////////////////////////////////////////////
   // per-channel datapath, each with its own enable and selector

   for (genvar c = 0; c < CH_N; c++) begin : g_ch
      fpr_chan_if ch_if ();

      // configuration fans out per channel, no cross coupling
      // the millisecond pulse is the only shared signal and holds no
      // per-channel state, so one channel's selector never slows another
      assign ch_if.reading_valid = reading_valid[c];
      assign ch_if.temp = temp_reading[c];
      assign ch_if.low_limit = low_limit[c];
      assign ch_if.span = zone_span[c];
      assign ch_if.floor_duty = st_r.floor_duty[c];
      assign ch_if.slew_en = slew_en[c]; // R10
      assign ch_if.step_sel = step_sel[c];
      assign ch_if.ms_tick = st_r.ms_tick;
      assign duty_w[c] = ch_if.duty;

      fpr_target_calc u_calc (
         .aclk (aclk),
         .aresetn (aresetn),
         .ch (ch_if.calc)
      );

      fpr_slew_step u_slew (
         .aclk (aclk),
         .aresetn (aresetn),
         .ch (ch_if.slew)
      );
   end
endmodule // fpr_top

// ===== verification/fan_pwm_ramp_limiter_tb_top.sv
/*
 fan_pwm_ramp_limiter_tb_top: bus tasks, reference model and scenarios.
 assumes fpr_top with MS_CYCLES of 4 and fan models on the outputs.
*/
`timescale 1ns/1ps
module fan_pwm_ramp_limiter_tb_top;
   import fpr_pkg::*;
   localparam int MS = 4;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, lock_status;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [AXI_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [CH_N-1:0] reading_valid = '0;
   logic [CH_N-1:0][7:0] temp_reading = '0, low_limit = '0, zone_span = '0, duty_out;
   logic [31:0] seed = 32'h0000000A;
   logic [7:0] t;
   int mismatches = 0, n_compared = 0, n, lk = 0;
   int rg [5] = '{'hE0, 0, 'h80, 'h80, 'h80};
   int ms_tab [8] = '{206, 104, 69, 41, 26, 18, 10, 5};

   always #5 aclk = ~aclk;

   fpr_top #(.MS_CYCLES(MS)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reading_valid, .temp_reading, .low_limit,
      .zone_span, .duty_out, .lock_status);
   fpr_fan_model fan_u [CH_N-1:0] (.aclk, .aresetn, .duty(duty_out), .rpm());
   ////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
      end
   endtask

   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   // address and data offered together, each dropped once taken
   task automatic wr(int idx, logic [31:0] v, logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= 12'(idx * 4);
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1;
      @(posedge aclk);
      s_axi_bready <= 0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask

   task automatic rdc(int idx, logic [31:0] e, logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= 12'(idx * 4);
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1;
      @(posedge aclk);
      s_axi_rready <= 0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask

   // write plus model update; locked writes leave the model alone
   task automatic wm(int idx, int v);
      wr(idx, v, RESP_OKAY);
      if (!lk && idx < 'h67) rg[idx - 'h62] = (idx == 'h62) ? ('hE0 | v & 'hF) : v & 'hFF;
      if (idx == 'h70 && v[0]) lk = 1;
   endtask

   function automatic int tgt(int c);
      int d = $signed(temp_reading[c]) - $signed(low_limit[c]);
      int f = rg[2 + c];
      if (d <= 0) return f;
      if (d >= zone_span[c]) return 255;
      return f + (255 - f) * d / zone_span[c];
   endfunction

   task automatic pulse();
      reading_valid <= 3'h7;
      @(posedge aclk);
      reading_valid <= 3'h0;
      repeat (2) @(posedge aclk);
      #1;
   endtask

   task automatic step_wait(int c, output int cyc);
      logic [7:0] v;
      v = duty_out[c];
      cyc = 0;
      do begin
         @(posedge aclk);
         cyc++;
      end while (duty_out[c] === v);
      chk("step", v + 1, duty_out[c]);
   endtask

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 5; i++) rdc(IDX_SLEW1 + i, rg[i], RESP_OKAY);
      rdc(8'h10, 0, RESP_SLVERR);
      wr(8'h10, 32'hFFFFFFFF, RESP_SLVERR);
      wm(IDX_SLEW1, 'h07);
      rdc(IDX_SLEW1, rg[0], RESP_OKAY);
      $display("test registers done");
      // floors at both ends of the scale, readings straddle the limit
      wm(IDX_FLOOR1, 'h00);
      wm(IDX_FLOOR2, 'hFF);
      wm(IDX_FLOOR3, xs());
      for (int k = 0; k < 40; k++) begin
         @(posedge aclk);
         for (int c = 0; c < CH_N; c++) begin
            t = xs();
            temp_reading[c] <= t;
            low_limit[c] <= t - (xs() & 8'h1F) + 8'h08;
            zone_span[c] <= xs() & 8'h1F;
         end
         pulse();
         for (int c = 0; c < CH_N; c++) chk("duty", tgt(c), duty_out[c]);
      end
      rdc(IDX_DUTY, tgt(0) | tgt(1) << 8 | tgt(2) << 16, RESP_OKAY);
      $display("test direct duty done");
      // every selector: channels 2 and 3 take turns ramping, the rest jump
      wm(IDX_FLOOR2, 'h00);
      wm(IDX_FLOOR3, 'h00);
      for (int s = 0; s < 8; s++) begin
         int c;
         c = 1 + s % 2;
         wm(IDX_SLEW23, 0);
         @(posedge aclk);
         temp_reading <= '0;
         low_limit <= '0;
         pulse();
         chk("floor", 0, duty_out[c]);
         wm(IDX_SLEW23, (8 | s) << (c == 1 ? 4 : 0));
         @(posedge aclk);
         temp_reading <= {3{8'h7F}};
         zone_span <= {3{8'h01}};
         pulse();
         chk("direct", 'hFF, duty_out[0]);
         chk("direct", 'hFF, duty_out[3 - c]);
         chk("no jump", 1, 32'(duty_out[c] < 8'h02));
         step_wait(c, n);
         step_wait(c, n);
         chk("interval", ms_tab[s] * MS, n);
      end
      @(posedge aclk);
      temp_reading <= '0;
      pulse();
      chk("no drop", 2, duty_out[2]);
      repeat (40 * MS * 5) @(posedge aclk);
      chk("ramp down", 0, duty_out[2]);
      // channel 1 ramps from its own register while channel 2 jumps and channel 3 ramps too
      wm(IDX_SLEW1, 'h0F);
      @(posedge aclk);
      temp_reading <= {3{8'h7F}};
      pulse();
      chk("no jump", 1, 32'(duty_out[0] < 8'h02));
      step_wait(0, n);
      step_wait(0, n);
      chk("interval", ms_tab[7] * MS, n);
      $display("test ramp done");
      // lock freezes the table, a zero write cannot undo it
      wm(IDX_LOCK, 1);
      wm(IDX_FLOOR1, 'h5A);
      wm(IDX_SLEW23, 'h77);
      wm(IDX_LOCK, 0);
      for (int i = 0; i < 5; i++) rdc(IDX_SLEW1 + i, rg[i], RESP_OKAY);
      rdc(IDX_LOCK, 1, RESP_OKAY);
      chk("lock", 1, lock_status);
      $display("test lock done");
      print_verdict();
   end

   // normal run is under 20k cycles, so this span only ends a hang
   initial begin
      #600us;
      mismatches++;
      print_verdict();
   end
endmodule // fan_pwm_ramp_limiter_tb_top

// ===== verification/fpr_fan_model.sv
/*
 fpr_fan_model: one fan whose speed follows the commanded duty.
 assumes duty is a level, 8'hFF full speed.
*/
`timescale 1ns/1ps
module fpr_fan_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] duty,
   output int rpm
);
   // rotor inertia: speed creeps toward the command, so jumps stay audible
   always @(posedge aclk) begin
      if (!aresetn) rpm <= 0;
      else rpm <= rpm + (int'(duty) * 10 - rpm) / 16;
   end
endmodule // fpr_fan_model

// ===== verification/fpr_props.sv
/*
 fpr_props: bus handshake, lock and duty-jump checks on fpr_top ports.
 assumes one aclk domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module fpr_props
   import fpr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [CH_N-1:0] reading_valid,
   input wire logic [CH_N-1:0][7:0] duty_out,
   input wire logic lock_status
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////
   // handshake steps
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   ////////////////////////////////////////////////////////////////////
   wr_answer_a: assert property (s_wr_take ##0 !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
   aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("aw taken twice");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rd_answer_a: assert property (s_rd_take |=> s_axi_rvalid) else $error("read answer late");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open while busy");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
      else $error("read answer dropped");
   lock_keep_a: assert property (lock_status |=> lock_status) else $error("lock cleared");
   // a direct jump needs a reading two or three edges back; ramps move one count
   jump_cause_a: assert property ($changed(duty_out[0]) && duty_out[0] != $past(duty_out[0]) + 8'h01
      && duty_out[0] + 8'h01 != $past(duty_out[0]) |-> $past(reading_valid[0], 2) || $past(reading_valid[0], 3))
      else $error("duty jumped without reading");
endmodule // fpr_props

bind fpr_top fpr_props props_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .reading_valid, .duty_out, .lock_status);
